// ===== design/cycle_count_pkg.sv
/*
 cycle_count_pkg: model-specific register addresses, field positions, reset values and widths
 shared by the cycle-count block, its freeze unit and its counters.
 assumes: addresses other than the bus frequency register are local choices of this core.
*/
package cycle_count_pkg;
    // register addresses
    localparam logic [31:0] ADDR_STAMP = 32'h0000_0010;
    localparam logic [31:0] ADDR_PLATFORM = 32'h0000_0017;
    localparam logic [31:0] ADDR_BUS_FREQ = 32'h0000_00CD;
    localparam logic [31:0] ADDR_MAXPERF = 32'h0000_00E7;
    localparam logic [31:0] ADDR_PERF_STATUS = 32'h0000_0198;
    localparam logic [31:0] ADDR_DBG_CTL = 32'h0000_01D9;
    localparam logic [31:0] ADDR_GEN_CTR = 32'h0000_0300;
    localparam logic [31:0] ADDR_FIXED_TWO = 32'h0000_030B;
    localparam logic [31:0] ADDR_CAPABILITY = 32'h0000_0345;
    localparam logic [31:0] ADDR_CNT_CFG = 32'h0000_0360;
    localparam logic [31:0] ADDR_GLOBAL_EN = 32'h0000_038F;
    localparam logic [31:0] ADDR_EVT_SEL = 32'h0000_03A0;
    localparam logic [31:0] ADDR_UNHALTED0 = 32'h0000_0400;
    localparam logic [31:0] ADDR_UNHALTED1 = 32'h0000_0401;
    localparam logic [31:0] ADDR_REF_TICKS = 32'h0000_0402;
    localparam logic [31:0] ADDR_LOCAL_TIMER = 32'h0000_0839;

    // counter configuration fields
    localparam int CFG_ENABLE_BIT = 12;
    localparam int CFG_COMPARE_BIT = 18;
    localparam int CFG_COMPLEMENT_BIT = 19;
    localparam int CFG_THR_LO = 20;
    localparam int THR_W = 4;
    // event selector fields
    localparam int EVT_USR_BIT = 2;
    localparam int EVT_OS_BIT = 3;
    localparam int EVT_CODE_LO = 25;
    localparam int EVT_CODE_W = 6;
    localparam logic [EVT_CODE_W-1:0] EVT_NULL = 6'h00;
    // debug control fields
    localparam int DBG_FREEZE_EN_BIT = 14;
    localparam logic [63:0] DBG_WRITE_MASK = 64'h0000_0000_0000_40C3;
    localparam logic [63:0] DBG_FREEZE_CLEAR = 64'h0000_0000_0000_00C3;
    localparam logic [63:0] DBG_RESET = 64'h0000_0000_0000_0000;
    // global counter enables
    localparam int GLB_W = 2;
    localparam int GLB_GEN_BIT = 0;
    localparam int GLB_FIX2_BIT = 1;
    localparam logic [GLB_W-1:0] GLB_ALL_ON = 2'h3;
    // capability fields and values
    localparam int CAP_FMT_LO = 0;
    localparam int CAP_TRAP_BIT = 6;
    localparam int CAP_REGS_BIT = 7;
    localparam int CAP_LAYOUT_LO = 8;
    localparam int CAP_FRZ_BIT = 12;
    localparam int CAP_FULLW_BIT = 13;
    localparam logic [5:0] CAP_FMT_VAL = 6'h00;
    localparam logic CAP_TRAP_VAL = 1'b0;
    localparam logic CAP_REGS_VAL = 1'b0;
    localparam logic [3:0] CAP_LAYOUT_VAL = 4'h0;
    localparam logic CAP_FRZ_VAL = 1'b1;
    localparam logic CAP_FULLW_VAL = 1'b0;
    // frequency and ratio fields
    localparam int BUS_FREQ_W = 3;
    localparam int RATIO_W = 5;
    localparam int PLAT_RATIO_LO = 8;
    localparam int STAT_XMODE_BIT = 31;
    localparam int STAT_RATIO_LO = 40;
    // counter widths
    localparam int GEN_W = 40;
    localparam int WIDE_W = 64;
endpackage : cycle_count_pkg

// ===== design/cycle_count_smm.sv
/*
 cycle_count_smm: clocktick counters, frequency and ratio reporting, capability enumeration and
 the freeze of counter enables and debug control around management mode.
 assumes: register requests, halt status, event counts and reference ticks come from core logic on clk;
 bus-clock-active and sleep are pins and are synchronised here.
*/
// Notes on behaviour
// - compare on, threshold 15, complement set: count every cycle, ignore privilege qualification.
// - selector needs a non-null event code; null keeps its counter stopped.
// - a counter counts only while its configuration enable bit is one.
// - non-sleep count runs while any logical processor is awake.
// - non-halted count advances each core cycle its logical processor is not halted.
// - power-saving state entered only when all logical processors halted.
// - stamp counter runs with bus clock active and sleep low; instruction reads it.
// - reference ticks count the fixed reference clock while not halted.
// - stamp, max-performance and fixed counter two share one fixed rate.
// - local interrupt-controller timer ignores core frequency transitions.
// - fixed rate equals bus frequency times maximum non-turbo ratio.
// - bus frequency code sits in bits 2:0 of register 0CDH.
// - ratio in platform bits 12:8, or status bits 44:40 when extreme mode on.
// - status bit 31 reports extreme mode, read-only.
// - capability: format 5:0, trap flag 6, saved-registers flag 7, layout 11:8.
// - capability bit 12 freeze supported, bit 13 full-width write alias.
// - capability register exists only when the identification flag reports one.
// - freezing entry clears global enables, saves debug control, clears trace fields.
// - return sets global enables to one and restores saved debug control.
`timescale 1ns/10ps
module cycle_count_smm (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic msr_req,
    input wire logic msr_we,
    input wire logic [31:0] msr_addr,
    input wire logic [63:0] msr_wdata,
    output logic msr_ack,
    output logic msr_fault,
    output logic [63:0] msr_rdata,
    input wire logic stamp_req,
    output logic stamp_valid,
    output logic [63:0] stamp_data,
    input wire logic bus_clk_active_pin,
    input wire logic sleep_pin,
    input wire logic bus_ref_tick,
    input wire logic [1:0] lp_halted,
    input wire logic lp_user_mode,
    input wire logic [cycle_count_pkg::THR_W-1:0] event_count,
    input wire logic [cycle_count_pkg::BUS_FREQ_W-1:0] bus_freq_strap,
    input wire logic [cycle_count_pkg::RATIO_W-1:0] base_ratio_strap,
    input wire logic [cycle_count_pkg::RATIO_W-1:0] xmode_ratio_strap,
    input wire logic xmode_strap,
    input wire logic cap_present_strap,
    input wire logic management_interrupt,
    input wire logic management_return,
    output logic power_save,
    output logic mgmt_active,
    output logic [63:0] debug_control
);
    import cycle_count_pkg::*;

    typedef struct packed {
        logic [1:0] bus_act_sync;
        logic [1:0] sleep_sync;
        logic straps_taken;
        logic [BUS_FREQ_W-1:0] bus_freq;
        logic [RATIO_W-1:0] base_ratio;
        logic [RATIO_W-1:0] xmode_ratio;
        logic xmode_on;
        logic cap_present;
        logic power_save;
        logic [63:0] dbg_ctl;
        logic [GLB_W-1:0] glb_en;
        logic [63:0] evt_sel;
        logic [63:0] cnt_cfg;
        logic ack;
        logic fault;
        logic [63:0] rdata;
        logic stamp_valid;
        logic [63:0] stamp_data;
    } top_state_s;

    top_state_s s_q;
    top_state_s s_d;

    freeze_if fz ();

    logic [WIDE_W-1:0] stamp_cnt;
    logic [WIDE_W-1:0] maxperf_cnt;
    logic [WIDE_W-1:0] fix2_cnt;
    logic [GEN_W-1:0] gen_cnt;
    logic [WIDE_W-1:0] unhalted0_cnt;
    logic [WIDE_W-1:0] unhalted1_cnt;
    logic [WIDE_W-1:0] ref_cnt;
    logic [WIDE_W-1:0] ltimer_cnt;

    logic [RATIO_W-1:0] resolved_ratio;
    logic fixed_rate_step;
    logic [RATIO_W-1:0] fixed_inc;
    logic [RATIO_W-1:0] fix2_inc;
    logic qualified;
    logic [THR_W-1:0] qual_events;
    logic thr_met;
    logic gen_run;
    logic [THR_W-1:0] gen_inc;
    logic gen_load;
    logic wr;
    logic rd;
    logic [63:0] cap_word;
    logic [63:0] dbg_mask;

    assign resolved_ratio = s_q.xmode_on ? s_q.xmode_ratio : s_q.base_ratio;
    // one bus reference tick advances by the ratio: the sum tracks bus frequency times ratio
    assign fixed_rate_step = s_q.bus_act_sync[1] && !s_q.sleep_sync[1] && bus_ref_tick;
    assign fixed_inc = fixed_rate_step ? resolved_ratio : '0;
    assign fix2_inc = s_q.glb_en[GLB_FIX2_BIT] ? fixed_inc : '0;

    // privilege qualification feeds the raw count; the threshold path then decides the step
    assign qualified = (s_q.evt_sel[EVT_USR_BIT] && lp_user_mode) || (s_q.evt_sel[EVT_OS_BIT] && !lp_user_mode);
    assign qual_events = qualified ? event_count : '0;
    // complement with threshold 15 is always met, which drops any qualification
    assign thr_met = s_q.cnt_cfg[CFG_COMPLEMENT_BIT] ?
                     (qual_events <= s_q.cnt_cfg[CFG_THR_LO +: THR_W]) :
                     (qual_events > s_q.cnt_cfg[CFG_THR_LO +: THR_W]);
    assign gen_run = s_q.cnt_cfg[CFG_ENABLE_BIT]
                     && s_q.evt_sel[EVT_CODE_LO +: EVT_CODE_W] != EVT_NULL
                     && s_q.glb_en[GLB_GEN_BIT]
                     && !s_q.power_save;
    assign gen_inc = !gen_run ? '0 :
                     s_q.cnt_cfg[CFG_COMPARE_BIT] ? THR_W'(thr_met) : qual_events;

    assign wr = msr_req && msr_we;
    assign rd = msr_req && !msr_we;
    assign gen_load = wr && msr_addr == ADDR_GEN_CTR;

    assign cap_word = 64'({CAP_FULLW_VAL, CAP_FRZ_VAL, CAP_LAYOUT_VAL, CAP_REGS_VAL,
                           CAP_TRAP_VAL, CAP_FMT_VAL});
    // freeze enable is writable only where the capability says it is supported
    assign dbg_mask = CAP_FRZ_VAL ? DBG_WRITE_MASK : (DBG_WRITE_MASK & ~(64'h1 << DBG_FREEZE_EN_BIT));

    assign fz.mgmt_interrupt = management_interrupt;
    assign fz.mgmt_return = management_return;
    assign fz.freeze_enable = s_q.dbg_ctl[DBG_FREEZE_EN_BIT] && CAP_FRZ_VAL;
    assign fz.dbg_now = s_q.dbg_ctl;

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.fault = 1'b0;
        s_d.stamp_valid = 1'b0;
        s_d.bus_act_sync = {s_q.bus_act_sync[0], bus_clk_active_pin};
        s_d.sleep_sync = {s_q.sleep_sync[0], sleep_pin};
        s_d.power_save = &lp_halted;
        // straps are caught once, on the first edge after reset release
        if (!s_q.straps_taken) begin
            s_d.straps_taken = 1'b1;
            s_d.bus_freq = bus_freq_strap;
            s_d.base_ratio = base_ratio_strap;
            s_d.xmode_ratio = xmode_ratio_strap;
            s_d.xmode_on = xmode_strap;
            s_d.cap_present = cap_present_strap;
        end
        if (msr_req) begin
            s_d.ack = 1'b1;
        end
        if (wr) begin
            if (msr_addr == ADDR_DBG_CTL) begin
                s_d.dbg_ctl = msr_wdata & dbg_mask;
            end else if (msr_addr == ADDR_GLOBAL_EN) begin
                s_d.glb_en = msr_wdata[GLB_W-1:0];
            end else if (msr_addr == ADDR_EVT_SEL) begin
                s_d.evt_sel = msr_wdata;
            end else if (msr_addr == ADDR_CNT_CFG) begin
                s_d.cnt_cfg = msr_wdata;
            end else if (msr_addr == ADDR_GEN_CTR) begin
                s_d.fault = 1'b0;
            end else begin
                // read-only and unmapped addresses refuse writes
                s_d.fault = 1'b1;
            end
        end
        if (rd) begin
            s_d.rdata = '0;
            if (msr_addr == ADDR_BUS_FREQ) begin
                s_d.rdata = 64'(s_q.bus_freq);
            end else if (msr_addr == ADDR_PLATFORM) begin
                s_d.rdata[PLAT_RATIO_LO +: RATIO_W] = s_q.base_ratio;
            end else if (msr_addr == ADDR_PERF_STATUS) begin
                s_d.rdata[STAT_XMODE_BIT] = s_q.xmode_on;
                s_d.rdata[STAT_RATIO_LO +: RATIO_W] = s_q.xmode_ratio;
            end else if (msr_addr == ADDR_CAPABILITY && s_q.cap_present) begin
                s_d.rdata = cap_word;
            end else if (msr_addr == ADDR_DBG_CTL) begin
                s_d.rdata = s_q.dbg_ctl;
            end else if (msr_addr == ADDR_GLOBAL_EN) begin
                s_d.rdata = 64'(s_q.glb_en);
            end else if (msr_addr == ADDR_EVT_SEL) begin
                s_d.rdata = s_q.evt_sel;
            end else if (msr_addr == ADDR_CNT_CFG) begin
                s_d.rdata = s_q.cnt_cfg;
            end else if (msr_addr == ADDR_GEN_CTR) begin
                s_d.rdata = 64'(gen_cnt);
            end else if (msr_addr == ADDR_STAMP) begin
                s_d.rdata = stamp_cnt;
            end else if (msr_addr == ADDR_MAXPERF) begin
                s_d.rdata = maxperf_cnt;
            end else if (msr_addr == ADDR_FIXED_TWO) begin
                s_d.rdata = fix2_cnt;
            end else if (msr_addr == ADDR_UNHALTED0) begin
                s_d.rdata = unhalted0_cnt;
            end else if (msr_addr == ADDR_UNHALTED1) begin
                s_d.rdata = unhalted1_cnt;
            end else if (msr_addr == ADDR_REF_TICKS) begin
                s_d.rdata = ref_cnt;
            end else if (msr_addr == ADDR_LOCAL_TIMER) begin
                s_d.rdata = ltimer_cnt;
            end else begin
                // absent capability register falls here too and faults
                s_d.fault = 1'b1;
            end
        end
        // hardware freeze and restore win over a software write in the same cycle
        if (fz.enter) begin
            s_d.glb_en = '0;
            s_d.dbg_ctl = s_q.dbg_ctl & ~DBG_FREEZE_CLEAR;
        end else if (fz.leave) begin
            s_d.glb_en = GLB_ALL_ON;
            s_d.dbg_ctl = fz.dbg_saved;
        end
        if (stamp_req) begin
            s_d.stamp_valid = 1'b1;
            s_d.stamp_data = stamp_cnt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.dbg_ctl <= DBG_RESET;
            s_q.glb_en <= GLB_ALL_ON;
        end else begin
            s_q <= s_d;
        end
    end

    mgmt_freeze_unit u_freeze (
        .clk(clk),
        .reset_n(reset_n),
        .fz(fz.unit)
    );

    tick_counter #(.W(WIDE_W), .IW(RATIO_W)) u_stamp (
        .clk(clk),
        .reset_n(reset_n),
        .inc(fixed_inc),
        .load(1'b0),
        .load_val('0),
        .count(stamp_cnt)
    );

    tick_counter #(.W(WIDE_W), .IW(RATIO_W)) u_maxperf (
        .clk(clk),
        .reset_n(reset_n),
        .inc(fixed_inc),
        .load(1'b0),
        .load_val('0),
        .count(maxperf_cnt)
    );

    tick_counter #(.W(WIDE_W), .IW(RATIO_W)) u_fixed_two (
        .clk(clk),
        .reset_n(reset_n),
        .inc(fix2_inc),
        .load(1'b0),
        .load_val('0),
        .count(fix2_cnt)
    );

    // general counter: non-sleep cycles when programmed with the threshold trick
    tick_counter #(.W(GEN_W), .IW(THR_W)) u_gen (
        .clk(clk),
        .reset_n(reset_n),
        .inc(gen_inc),
        .load(gen_load),
        .load_val(msr_wdata[GEN_W-1:0]),
        .count(gen_cnt)
    );

    // halt-transition cycles are counted while the halt flag is still low
    tick_counter #(.W(WIDE_W), .IW(1)) u_unhalted0 (
        .clk(clk),
        .reset_n(reset_n),
        .inc(!lp_halted[0]),
        .load(1'b0),
        .load_val('0),
        .count(unhalted0_cnt)
    );

    tick_counter #(.W(WIDE_W), .IW(1)) u_unhalted1 (
        .clk(clk),
        .reset_n(reset_n),
        .inc(!lp_halted[1]),
        .load(1'b0),
        .load_val('0),
        .count(unhalted1_cnt)
    );

    tick_counter #(.W(WIDE_W), .IW(1)) u_ref (
        .clk(clk),
        .reset_n(reset_n),
        .inc(bus_ref_tick && !lp_halted[0]),
        .load(1'b0),
        .load_val('0),
        .count(ref_cnt)
    );

    // reference tick only, so core ratio changes never reach it
    tick_counter #(.W(WIDE_W), .IW(1)) u_local_timer (
        .clk(clk),
        .reset_n(reset_n),
        .inc(bus_ref_tick),
        .load(1'b0),
        .load_val('0),
        .count(ltimer_cnt)
    );

    assign msr_ack = s_q.ack;
    assign msr_fault = s_q.fault;
    assign msr_rdata = s_q.rdata;
    assign stamp_valid = s_q.stamp_valid;
    assign stamp_data = s_q.stamp_data;
    assign power_save = s_q.power_save;
    assign mgmt_active = fz.in_mgmt;
    assign debug_control = s_q.dbg_ctl;
endmodule : cycle_count_smm

// ===== design/freeze_if.sv
/*
 freeze_if: carries the management-mode freeze handshake between the block core and its freeze unit.
 assumes: one clock; enter and leave are one-cycle pulses.
*/
`timescale 1ns/10ps
interface freeze_if;
    logic mgmt_interrupt;
    logic mgmt_return;
    logic freeze_enable;
    logic [63:0] dbg_now;
    logic [63:0] dbg_saved;
    logic in_mgmt;
    logic enter;
    logic leave;
    modport unit (input mgmt_interrupt, input mgmt_return, input freeze_enable, input dbg_now,
                  output dbg_saved, output in_mgmt, output enter, output leave);
    modport core (output mgmt_interrupt, output mgmt_return, output freeze_enable, output dbg_now,
                  input dbg_saved, input in_mgmt, input enter, input leave);
endinterface : freeze_if

// ===== design/mgmt_freeze_unit.sv
/*
 mgmt_freeze_unit: tracks management mode and keeps the debug-control copy taken at entry.
 assumes: interrupt and return pulses come from core logic on the same clock.
*/
`timescale 1ns/10ps
module mgmt_freeze_unit (
    input wire logic clk,
    input wire logic reset_n,
    freeze_if.unit fz
);
    import cycle_count_pkg::*;

    typedef struct packed {
        logic in_mgmt;
        logic frozen;
        logic [63:0] saved;
    } frz_state_s;

    frz_state_s s_q;
    frz_state_s s_d;

    always_comb begin
        s_d = s_q;
        fz.enter = 1'b0;
        fz.leave = 1'b0;
        if (fz.mgmt_interrupt && !s_q.in_mgmt) begin
            s_d.in_mgmt = 1'b1;
            // copy only when freezing, so a plain entry never restores stale state
            if (fz.freeze_enable) begin
                s_d.frozen = 1'b1;
                s_d.saved = fz.dbg_now;
                fz.enter = 1'b1;
            end
        end else if (fz.mgmt_return && s_q.in_mgmt) begin
            s_d.in_mgmt = 1'b0;
            s_d.frozen = 1'b0;
            fz.leave = s_q.frozen;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fz.dbg_saved = s_q.saved;
    assign fz.in_mgmt = s_q.in_mgmt;
endmodule : mgmt_freeze_unit

// ===== design/tick_counter.sv
/*
 tick_counter: free-running up counter with a variable increment and a load port.
 assumes: increment and load come from logic on the same clock; load wins over counting.
*/
`timescale 1ns/10ps
module tick_counter #(
    parameter int W = 64,
    parameter int IW = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [IW-1:0] inc,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic [W-1:0] count
);
    import cycle_count_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } cnt_state_s;

    cnt_state_s s_q;
    cnt_state_s s_d;

    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.cnt = load_val;
        end else begin
            s_d.cnt = s_q.cnt + W'(inc);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;
endmodule : tick_counter

// ===== test/cycle_count_smm_sva.sv
/* cycle_count_smm_sva: port assertions for the cycle-count block.
 assumes: bound into every cycle_count_smm; one clock, async active-low reset. */
`timescale 1ns/10ps
module cycle_count_smm_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic msr_req,
    input wire logic msr_we,
    input wire logic msr_ack,
    input wire logic msr_fault,
    input wire logic stamp_req,
    input wire logic stamp_valid,
    input wire logic [1:0] lp_halted,
    input wire logic management_interrupt,
    input wire logic management_return,
    input wire logic power_save,
    input wire logic mgmt_active,
    input wire logic [63:0] debug_control
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_ack_next: assert property (msr_req |=> msr_ack) else $error("ack missing");
    a_ack_cause: assert property (msr_ack |-> $past(msr_req)) else $error("ack unasked");
    a_fault_ack: assert property (msr_fault |-> msr_ack) else $error("fault without ack");
    a_stamp_answer: assert property (stamp_req |=> stamp_valid) else $error("stamp missing");
    a_stamp_cause: assert property (stamp_valid |-> $past(stamp_req)) else $error("stamp unasked");
    a_save_all_halt: assert property (&lp_halted |=> power_save) else $error("power save late");
    a_save_needs_halt: assert property (power_save |-> &$past(lp_halted)) else $error("power save early");
    a_mode_enter: assert property (management_interrupt && !mgmt_active |=> mgmt_active)
        else $error("no entry");
    a_mode_leave: assert property (management_return && mgmt_active |=> !mgmt_active)
        else $error("no exit");
    a_freeze_clear: assert property (management_interrupt && !mgmt_active && debug_control[14]
        |=> (debug_control & 64'h0000_0000_0000_00C3) == 64'h0) else $error("trace fields kept");
    // a write on the bus or a mode change is the only legal cause of a move
    a_dbg_cause: assert property ($changed(debug_control) |->
        $past(msr_req && msr_we || management_interrupt || management_return)) else $error("debug moved");
endmodule : cycle_count_smm_sva
bind cycle_count_smm cycle_count_smm_sva cycle_count_smm_sva_i (.clk(clk), .reset_n(reset_n),
    .msr_req(msr_req), .msr_we(msr_we), .msr_ack(msr_ack), .msr_fault(msr_fault), .stamp_req(stamp_req),
    .stamp_valid(stamp_valid), .lp_halted(lp_halted), .management_interrupt(management_interrupt),
    .management_return(management_return), .power_save(power_save), .mgmt_active(mgmt_active),
    .debug_control(debug_control));

// ===== test/cycle_count_smm_tb_top.sv
/* cycle_count_smm_tb_top: self-checking bench, random straps and traffic with corner cases.
 assumes: 100 MHz clock; the checker is bound to the design instance. */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module cycle_count_smm_tb_top;
    import cycle_count_pkg::*;
    localparam logic [31:0] AD [4] = '{ADDR_UNHALTED0, ADDR_UNHALTED1, ADDR_REF_TICKS, ADDR_LOCAL_TIMER};
    localparam logic [63:0] EN = 64'h1000;
    localparam logic [63:0] CMP = 64'h00FC_1000;
    logic clk, reset_n, msr_req, msr_we, msr_ack, msr_fault, stamp_req, stamp_valid, flt;
    logic bus_act, sleep_pin, tick, user, xmode, cap, m_int, m_ret, power_save, mgmt_active;
    logic [31:0] msr_addr;
    logic [63:0] msr_wdata, msr_rdata, stamp_data, debug_control, rd, a0, b0, c0, evt;
    logic [1:0] lp_halted;
    logic [THR_W-1:0] ev;
    logic [BUS_FREQ_W-1:0] freq;
    logic [RATIO_W-1:0] base_r, xr, r;
    int errors, checks, cycles, k;
    cycle_count_smm cycle_count_smm_i (.clk(clk), .reset_n(reset_n), .msr_req(msr_req), .msr_we(msr_we),
        .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_ack(msr_ack), .msr_fault(msr_fault),
        .msr_rdata(msr_rdata), .stamp_req(stamp_req), .stamp_valid(stamp_valid), .stamp_data(stamp_data),
        .bus_clk_active_pin(bus_act), .sleep_pin(sleep_pin), .bus_ref_tick(tick), .lp_halted(lp_halted),
        .lp_user_mode(user), .event_count(ev), .bus_freq_strap(freq), .base_ratio_strap(base_r),
        .xmode_ratio_strap(xr), .xmode_strap(xmode), .cap_present_strap(cap), .management_interrupt(m_int),
        .management_return(m_ret), .power_save(power_save), .mgmt_active(mgmt_active),
        .debug_control(debug_control));
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    // one request, released at the taking edge; the answer is read once it has landed
    task automatic msr(input logic we, input logic [31:0] a, input logic [63:0] wd);
        @(posedge clk);
        {msr_req, msr_we, msr_addr, msr_wdata} <= {1'b1, we, a, wd};
        @(posedge clk);
        msr_req <= 1'b0;
        #1;
        rd = msr_rdata;
        flt = msr_fault;
        `CHK("ack", 1'b1, msr_ack)
    endtask : msr
    task automatic stamp(output logic [63:0] v);
        @(posedge clk);
        stamp_req <= 1'b1;
        @(posedge clk);
        stamp_req <= 1'b0;
        #1;
        v = stamp_data;
        `CHK("stamp_valid", 1'b1, stamp_valid)
    endtask : stamp
    task automatic ticks(input int n);
        @(posedge clk);
        tick <= 1'b1;
        repeat (n) @(posedge clk);
        tick <= 1'b0;
    endtask : ticks
    // two reads two cycles apart give the count of those two cycles
    task automatic cnt(input logic [63:0] cfg, input logic [63:0] sel, input logic [63:0] exp);
        msr(1'b1, ADDR_EVT_SEL, sel);
        msr(1'b1, ADDR_CNT_CFG, cfg);
        msr(1'b0, ADDR_GEN_CTR, 64'h0);
        a0 = rd;
        msr(1'b0, ADDR_GEN_CTR, 64'h0);
        `CHK("gen_delta", exp, rd - a0)
    endtask : cnt
    task automatic mgmt(input logic ent);
        @(posedge clk);
        {m_int, m_ret} <= {ent, !ent};
        @(posedge clk);
        {m_int, m_ret} <= 2'b00;
        repeat (2) @(posedge clk);
        #1;
    endtask : mgmt
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // the run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        {reset_n, msr_req, msr_we, stamp_req, sleep_pin, tick, user, m_int, m_ret, xmode, cap} = '0;
        {msr_addr, msr_wdata, ev, freq, base_r, xr, bus_act, lp_halted} = '0;
        void'($urandom(82460));
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            {reset_n, xmode, cap, bus_act, sleep_pin, user, lp_halted} <= {1'b0, p[0], !p[0], 3'b100, 2'h1};
            {freq, base_r, xr, ev} <= {3'($urandom), 5'($urandom_range(31, 1)), 5'($urandom_range(31, 1)),
                4'($urandom)};
            repeat (5) @(posedge clk);
            reset_n <= 1'b1;
            repeat (2) @(posedge clk);
            r = p ? xr : base_r;
            msr(1'b0, ADDR_BUS_FREQ, 64'h0);
            `CHK("freq", {61'h0, freq}, rd)
            msr(1'b0, ADDR_PLATFORM, 64'h0);
            `CHK("plat_ratio", base_r, rd[12:8])
            msr(1'b0, ADDR_PERF_STATUS, 64'h0);
            `CHK("stat", {xr, p[0]}, {rd[44:40], rd[31]})
            msr(1'b1, ADDR_PERF_STATUS, '1);
            `CHK("stat_wr", 1'b1, flt)
            msr(1'b0, 32'h0000_0123, 64'h0);
            `CHK("unmapped", 1'b1, flt)
            msr(1'b0, ADDR_CAPABILITY, 64'h0);
            if (p == 0) `CHK("cap", {CAP_FULLW_VAL, CAP_FRZ_VAL, CAP_LAYOUT_VAL, CAP_REGS_VAL, CAP_TRAP_VAL,
                CAP_FMT_VAL}, rd[13:0])
            else `CHK("cap_absent", 1'b1, flt)
            stamp(a0);
            msr(1'b0, ADDR_MAXPERF, 64'h0);
            b0 = rd;
            msr(1'b0, ADDR_FIXED_TWO, 64'h0);
            c0 = rd;
            k = $urandom_range(9, 1);
            ticks(k);
            stamp(rd);
            `CHK("stamp", a0 + 64'(k * r), rd)
            msr(1'b0, ADDR_MAXPERF, 64'h0);
            `CHK("maxperf", b0 + 64'(k * r), rd)
            msr(1'b0, ADDR_FIXED_TWO, 64'h0);
            `CHK("fixed_two", c0 + 64'(k * r), rd)
            @(posedge clk);
            {bus_act, sleep_pin} <= p ? 2'b00 : 2'b11;
            repeat (3) @(posedge clk);
            stamp(a0);
            ticks(k);
            stamp(rd);
            `CHK("stamp_stop", a0, rd)
            {bus_act, sleep_pin, tick, lp_halted} <= {3'b101, p ? 2'h2 : 2'h1};
            for (int i = 0; i < 4; i++) begin
                msr(1'b0, AD[i], 64'h0);
                a0 = rd;
                msr(1'b0, AD[i], 64'h0);
                `CHK("delta", 64'((i == 3 || !lp_halted[i % 2]) ? 2 : 0), rd - a0)
            end
            tick <= 1'b0;
            evt = 64'($urandom_range(63, 1)) << EVT_CODE_LO;
            cnt(CMP, evt, 64'h2);
            user <= 1'b1;
            cnt(EN, evt | 64'h4, 64'(2 * ev));
            cnt(CMP & ~EN, evt, 64'h0);
            cnt(CMP, 64'h0, 64'h0);
            lp_halted <= 2'h3;
            cnt(CMP, evt, 64'h0);
            `CHK("power_save", 1'b1, power_save)
            // freeze enable only in pass 0, where the capability register is present
            a0 = {$urandom, $urandom} & ~64'h4000 | (p ? 64'h0 : 64'h4000);
            msr(1'b1, ADDR_DBG_CTL, a0);
            b0 = a0 & DBG_WRITE_MASK;
            mgmt(1'b1);
            `CHK("dbg_frozen", p ? b0 : b0 & ~64'hC3, debug_control)
            msr(1'b0, ADDR_GLOBAL_EN, 64'h0);
            `CHK("glb_frozen", p ? 64'h3 : 64'h0, rd)
            mgmt(1'b0);
            `CHK("dbg_back", b0, debug_control)
            msr(1'b0, ADDR_GLOBAL_EN, 64'h0);
            `CHK("glb_back", 64'h3, rd)
            $display("pass %0d done", p);
        end
        test_done();
    end
endmodule : cycle_count_smm_tb_top
